// ---- rtl/sdram_ctrl_end.sv ----
// memory controller end: link clock divider, command, write and read beats
`timescale 1ns/10ps
`include "sdram_link_regs.svh"

module sdram_ctrl_end #(
  parameter int DQ_W = `LINK_DQ_W,   // must match the interface
  parameter int AW   = `LINK_AW,
  parameter int NL   = (DQ_W >= 8) ? DQ_W / 8 : 1
) (
  input  wire logic                 clk,        // system clock
  input  wire logic                 srst,       // synchronous reset
  sdram_link_if.ctrl                link,       // pin side
  input  wire logic                 req_valid,  // request present
  output logic                      req_ready,  // request taken this cycle
  input  wire sdram_link_pkg::cmd_t req_cmd,    // request kind
  input  wire logic [2:0]           req_ba,     // bank or mode register
  input  wire logic [AW-1:0]        req_addr,   // address
  input  wire logic                 req_odt,    // termination level to drive
  input  wire logic [2*DQ_W-1:0]    req_wdata,  // beat 1 high, beat 0 low
  input  wire logic [2*NL-1:0]      req_wmask,  // mask per lane, beat 1 high
  output logic                      rsp_valid,  // read data pulse
  output logic [2*DQ_W-1:0]         rsp_rdata,  // beat 1 high, beat 0 low
  output logic                      init_done   // link out of reset
);
  import sdram_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // one state group: ck is derived here, so pins are sampled in clk directly
  logic [1:0]        phase_reg,  phase_next;
  logic [2:0]        init_reg,   init_next;
  logic              cke_reg,    cke_next;
  logic              cs_n_reg,   cs_n_next;
  logic [2:0]        code_reg,   code_next;
  logic [2:0]        ba_reg,     ba_next;
  logic [AW-1:0]     addr_reg,   addr_next;
  logic              odt_reg,    odt_next;
  logic [DQ_W-1:0]   dq_reg,     dq_next;
  logic [NL-1:0]     dm_reg,     dm_next;
  logic              oe_reg,     oe_next;
  logic [1:0]        wst_reg,    wst_next;
  logic [2*DQ_W-1:0] wbuf_reg,   wbuf_next;
  logic [2*NL-1:0]   wmsk_reg,   wmsk_next;
  logic [1:0]        rcnt_reg,   rcnt_next;
  logic [2*DQ_W-1:0] rdat_reg,   rdat_next;
  logic              rval_reg,   rval_next;
  logic              fire;

  // only one link transfer in flight keeps the device's column stable
  assign req_ready = (phase_reg == `PH_CMD) && (init_reg == `INIT_PERIODS)
                     && (wst_reg == 2'h0) && (rcnt_reg == 2'h0);
  assign fire      = req_valid && req_ready;

  always_comb begin
    phase_next = phase_reg + 2'h1;
    init_next  = init_reg;
    cke_next   = cke_reg;
    cs_n_next  = cs_n_reg;
    code_next  = code_reg;
    ba_next    = ba_reg;
    addr_next  = addr_reg;
    odt_next   = odt_reg;
    dq_next    = dq_reg;
    dm_next    = dm_reg;
    oe_next    = oe_reg;
    wst_next   = wst_reg;
    wbuf_next  = wbuf_reg;
    wmsk_next  = wmsk_reg;
    rcnt_next  = rcnt_reg;
    rdat_next  = rdat_reg;
    rval_next  = 1'b0;
    // command pins change a quarter period before the rising ck edge
    if (phase_reg == `PH_CMD) begin
      if (init_reg != `INIT_PERIODS) begin
        init_next = init_reg + 3'h1;
      end
      cs_n_next = 1'b1;
      code_next = `CODE_NOP;
      if (fire) begin
        ba_next   = req_ba;
        addr_next = req_addr;
        odt_next  = req_odt;
        wbuf_next = req_wdata;
        wmsk_next = req_wmask;
        cs_n_next = 1'b0;
        case (req_cmd)
          CMD_ACT:      code_next = `CODE_ACT;
          CMD_PRE:      code_next = `CODE_PRE;
          CMD_MODE:     code_next = `CODE_MODE;
          CMD_REFRESH:  code_next = `CODE_REFRESH;
          CMD_WRITE: begin
            code_next = `CODE_WRITE;
            wst_next  = 2'h1;
          end
          CMD_READ: begin
            code_next = `CODE_READ;
            rcnt_next = 2'h2;
          end
          CMD_SREF: begin
            code_next = `CODE_REFRESH;
            cke_next  = 1'b0;
          end
          CMD_PD_ENTER: begin
            cs_n_next = 1'b1;
            cke_next  = 1'b0;
          end
          CMD_PD_EXIT: begin
            cs_n_next = 1'b1;
            cke_next  = 1'b1;
          end
          default: begin
            cs_n_next = 1'b1;
          end
        endcase
      end else if (init_reg == (`INIT_PERIODS - 3'h1)) begin
        cke_next = 1'b1;
      end
      // write beat 0 is driven here so the rising ck edge sits mid-beat
      if (wst_reg == 2'h1) begin
        dq_next  = wbuf_reg[DQ_W-1:0];
        dm_next  = wmsk_reg[NL-1:0];
        oe_next  = 1'b1;
        wst_next = 2'h2;
      end else if (wst_reg == 2'h2) begin
        oe_next  = 1'b0;
        dm_next  = '0;
        wst_next = 2'h0;
      end
      if (rcnt_reg == 2'h2) begin
        rcnt_next = 2'h1;
      end else if (rcnt_reg == 2'h1) begin
        rdat_next[2*DQ_W-1:DQ_W] = link.dq;
        rval_next = 1'b1;
        rcnt_next = 2'h0;
      end
    end
    // beat 1 is driven, and read beat 0 taken, a quarter after rising ck
    if (phase_reg == `PH_BEAT1) begin
      if (wst_reg == 2'h2) begin
        dq_next = wbuf_reg[2*DQ_W-1:DQ_W];
        dm_next = wmsk_reg[2*NL-1:NL];
      end
      if (rcnt_reg == 2'h1) begin
        rdat_next[DQ_W-1:0] = link.dq;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_reg <= 2'h0;
      init_reg  <= 3'h0;
      cke_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      code_reg  <= `CODE_NOP;
      ba_reg    <= 3'h0;
      addr_reg  <= '0;
      odt_reg   <= 1'b0;
      dq_reg    <= '0;
      dm_reg    <= '0;
      oe_reg    <= 1'b0;
      wst_reg   <= 2'h0;
      wbuf_reg  <= '0;
      wmsk_reg  <= '0;
      rcnt_reg  <= 2'h0;
      rdat_reg  <= '0;
      rval_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      init_reg  <= init_next;
      cke_reg   <= cke_next;
      cs_n_reg  <= cs_n_next;
      code_reg  <= code_next;
      ba_reg    <= ba_next;
      addr_reg  <= addr_next;
      odt_reg   <= odt_next;
      dq_reg    <= dq_next;
      dm_reg    <= dm_next;
      oe_reg    <= oe_next;
      wst_reg   <= wst_next;
      wbuf_reg  <= wbuf_next;
      wmsk_reg  <= wmsk_next;
      rcnt_reg  <= rcnt_next;
      rdat_reg  <= rdat_next;
      rval_reg  <= rval_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: ck high in phases 1 and 2, so no pin changes on a ck edge
  // strobe is ck so its edges fall mid-beat
  assign link.ck       = phase_reg[1] ^ phase_reg[0];
  assign link.ck_n     = phase_reg[1] ~^ phase_reg[0];
  // released early: device reset must be over before the first command
  assign link.link_rst = (init_reg < `LINK_RST_PERIODS);
  assign link.cke      = cke_reg;
  assign link.cs_n     = cs_n_reg;
  assign {link.ras_n, link.cas_n, link.we_n} = code_reg;
  assign link.ba       = ba_reg;
  assign link.addr     = addr_reg;
  assign link.odt      = odt_reg;
  assign link.dm       = dm_reg;
  assign link.dq_c     = dq_reg;
  assign link.dq_c_oe  = oe_reg;
  assign link.dqs_c    = phase_reg[1] ^ phase_reg[0];
  assign link.dqs_c_oe = oe_reg;
  assign rsp_valid     = rval_reg;
  assign rsp_rdata     = rdat_reg;
  assign init_done     = (init_reg == `INIT_PERIODS);

endmodule // sdram_ctrl_end

// ---- rtl/sdram_dev_end.sv ----
// memory device end: pin sampling, power states, masked writes, reads, termination
`timescale 1ns/10ps
`include "sdram_link_regs.svh"

module sdram_dev_end #(
  parameter int DQ_W   = `LINK_DQ_W,   // 16, 8 or 4
  parameter int AW     = `LINK_AW,     // address pins
  parameter int MEM_AW = `DEV_MEM_AW   // storage index bits
) (
  input  wire logic               clk,        // user-side clock
  input  wire logic               srst,       // user-side reset
  sdram_link_if.mem               link,       // pin side, clocked by link.ck
  output sdram_link_pkg::pwr_state_t pwr_state, // power state, user clock
  output logic                    term_on     // termination active, user clock
);
  import sdram_link_pkg::*;

  localparam int LW    = (DQ_W >= 8) ? 8 : DQ_W;
  localparam int NL    = DQ_W / LW;
  localparam int DEPTH = 2 ** MEM_AW;

  ////////////////////////////////////////////////////////////////////////////
  // link reset arrives from the controller, synchronised to ck
  logic lrst_meta_reg;
  logic lrst_reg;

  always_ff @(posedge link.ck) begin
    lrst_meta_reg <= link.link_rst;
    lrst_reg      <= lrst_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // self refresh exit: cke rising edge caught with no help from ck
  logic srx_clr_reg;
  logic srx_clr_next;
  logic srx_flag_reg;
  logic srx_meta_reg;
  logic srx_reg;

  // clear is a flop so the async clear never sees decode glitches
  always_ff @(posedge link.cke or posedge srx_clr_reg) begin
    if (srx_clr_reg) begin
      srx_flag_reg <= 1'b0;
    end else begin
      srx_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge link.ck) begin
    srx_meta_reg <= srx_flag_reg;
    srx_reg      <= srx_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and power state, all sampled at rising ck
  pwr_state_t            pwr_reg,    pwr_next;
  logic [7:0]            open_reg,   open_next;
  logic [AW-1:0]         mode_reg  [0:3];
  logic [AW-1:0]         mode_next [0:3];
  logic                  wr_reg,     wr_next;
  logic                  rd_reg,     rd_next;
  logic                  commit_reg, commit_next;
  logic                  rd_act_reg, rd_act_next;
  logic                  tlink_reg,  tlink_next;
  logic [MEM_AW-2:0]     col_reg,    col_next;
  logic [MEM_AW-2:0]     ccol_reg,   ccol_next;
  logic [DQ_W-1:0]       b0_dq_reg,  b0_dq_next;
  logic [NL-1:0]         b0_dm_reg,  b0_dm_next;
  logic [DQ_W-1:0]       dq_pos_reg, dq_pos_next;
  logic [2:0]            code;
  logic                  cmd_ok;
  // storage, declared here because the decode reads its beat-0 port
  logic [DQ_W-1:0]       mem_rd0;
  logic [DQ_W-1:0]       mem_rd1;
  logic [DQ_W-1:0]       mem        [0:DEPTH-1];

  always_comb begin
    pwr_next    = pwr_reg;
    open_next   = open_reg;
    mode_next   = mode_reg;
    col_next    = col_reg;
    wr_next     = 1'b0;
    rd_next     = 1'b0;
    ccol_next   = col_reg;
    commit_next = wr_reg;
    code        = {link.ras_n, link.cas_n, link.we_n};
    // receivers off outside active state; cs_n high masks all
    cmd_ok      = (pwr_reg == PWR_ACTIVE) && link.cke && !link.cs_n;
    case (pwr_reg)
      PWR_ACTIVE: begin
        if (!link.cke) begin
          if (open_reg != 8'h00) begin
            pwr_next = PWR_ACT_PD;
          end else if (!link.cs_n && code == `CODE_REFRESH) begin
            pwr_next = PWR_SELF;
          end else begin
            pwr_next = PWR_PRE_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD: begin
        if (link.cke) begin
          pwr_next = PWR_ACTIVE;
        end
      end
      PWR_SELF: begin
        if (srx_reg) begin
          pwr_next = PWR_ACTIVE;
        end
      end
      default: begin
        pwr_next = PWR_ACTIVE;
      end
    endcase
    if (cmd_ok) begin
      case (code)
        `CODE_ACT: begin
          open_next[link.ba] = 1'b1;
        end
        `CODE_PRE: begin
          if (link.addr[`ADDR_AP_BIT]) begin
            open_next = 8'h00;
          end else begin
            open_next[link.ba] = 1'b0;
          end
        end
        `CODE_WRITE: begin
          wr_next  = 1'b1;
          col_next = link.addr[MEM_AW-2:0];
        end
        `CODE_READ: begin
          rd_next  = 1'b1;
          col_next = link.addr[MEM_AW-2:0];
        end
        `CODE_MODE: begin
          if (!link.ba[2]) begin
            mode_next[link.ba[1:0]] = link.addr;
          end
        end
        default: begin
        end
      endcase
    end
    // first write beat and its mask are taken at the rising edge
    b0_dq_next  = wr_reg ? link.dq : b0_dq_reg;
    b0_dm_next  = wr_reg ? link.dm : b0_dm_reg;
    // cke low at the beat edge disables the outputs
    rd_act_next = rd_reg && link.cke;
    dq_pos_next = mem_rd0;
    // odt counts only when allowed by mode register and not in self refresh
    tlink_next  = mode_reg[`EMR_INDEX][`EMR_TERM_BIT] && link.odt
                  && (pwr_reg != PWR_SELF);
    srx_clr_next = (pwr_next != PWR_SELF);
  end

  always_ff @(posedge link.ck) begin
    if (lrst_reg) begin
      pwr_reg     <= PWR_ACTIVE;
      open_reg    <= 8'h00;
      mode_reg    <= '{default: '0};
      wr_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      commit_reg  <= 1'b0;
      rd_act_reg  <= 1'b0;
      tlink_reg   <= 1'b0;
      srx_clr_reg <= 1'b1;
      col_reg     <= '0;
      ccol_reg    <= '0;
    end else begin
      pwr_reg     <= pwr_next;
      open_reg    <= open_next;
      mode_reg    <= mode_next;
      wr_reg      <= wr_next;
      rd_reg      <= rd_next;
      commit_reg  <= commit_next;
      rd_act_reg  <= rd_act_next;
      tlink_reg   <= tlink_next;
      srx_clr_reg <= srx_clr_next;
      col_reg     <= col_next;
      ccol_reg    <= ccol_next;
    end
    b0_dq_reg  <= b0_dq_next;
    b0_dm_reg  <= b0_dm_next;
    dq_pos_reg <= dq_pos_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge capture: second write beat, second read beat
  // strobe edges coincide with ck edges on this link, so ck clocks the beats
  logic [DQ_W-1:0] b1_dq_reg;
  logic [NL-1:0]   b1_dm_reg;
  logic [DQ_W-1:0] dq_neg_reg;

  assign mem_rd0 = mem[{col_reg, 1'b0}];
  assign mem_rd1 = mem[{col_reg, 1'b1}];

  always_ff @(negedge link.ck) begin
    b1_dq_reg  <= link.dq;
    b1_dm_reg  <= link.dm;
    dq_neg_reg <= mem_rd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane merge: a masked lane keeps what is stored
  logic [DQ_W-1:0] old0;
  logic [DQ_W-1:0] old1;
  logic [DQ_W-1:0] new0;
  logic [DQ_W-1:0] new1;

  assign old0 = mem[{ccol_reg, 1'b0}];
  assign old1 = mem[{ccol_reg, 1'b1}];

  for (genvar l = 0; l < NL; l++) begin : g_lane
    assign new0[l*LW +: LW] = b0_dm_reg[l] ? old0[l*LW +: LW]
                                           : b0_dq_reg[l*LW +: LW];
    assign new1[l*LW +: LW] = b1_dm_reg[l] ? old1[l*LW +: LW]
                                           : b1_dq_reg[l*LW +: LW];
  end

  // both beats land together one edge after the falling-edge beat
  always_ff @(posedge link.ck) begin
    if (commit_reg) begin
      mem[{ccol_reg, 1'b0}] <= new0;
      mem[{ccol_reg, 1'b1}] <= new1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read drive: beat changes on each ck edge, strobe follows ck
  // the ck-level mux is a model of a DDR output cell, not a gate to copy
  assign link.dq_d     = link.ck ? dq_pos_reg : dq_neg_reg;
  assign link.dq_d_oe  = rd_act_reg;
  assign link.dqs_d    = link.ck;
  assign link.dqs_d_oe = rd_act_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status to the user clock: two flops, then accept only a steady value
  // termination spans every dq, strobe and mask pin of this width
  logic [2:0] st_meta_reg;
  logic [2:0] st_sync_reg;
  logic [2:0] st_prev_reg, st_prev_next;
  logic [2:0] st_out_reg,  st_out_next;

  always_ff @(posedge clk) begin
    st_meta_reg <= {pwr_reg, tlink_reg};
    st_sync_reg <= st_meta_reg;
  end

  always_comb begin
    st_prev_next = st_sync_reg;
    st_out_next  = (st_sync_reg == st_prev_reg) ? st_sync_reg : st_out_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_prev_reg <= 3'h0;
      st_out_reg  <= 3'h0;
    end else begin
      st_prev_reg <= st_prev_next;
      st_out_reg  <= st_out_next;
    end
  end

  assign pwr_state = pwr_state_t'(st_out_reg[2:1]);
  assign term_on   = st_out_reg[0];

endmodule // sdram_dev_end

// ---- rtl/sdram_link_if.sv ----
// pin-level link between memory controller and memory device
`timescale 1ns/10ps
`include "sdram_link_regs.svh"

interface sdram_link_if #(
  parameter int DQ_W = `LINK_DQ_W,
  parameter int AW   = `LINK_AW
) ();
  localparam int LW = (DQ_W >= 8) ? 8 : DQ_W;
  localparam int NL = DQ_W / LW;

  logic            ck;        // link clock, true leg
  logic            ck_n;      // link clock, complement leg
  logic            link_rst;  // link-level reset from controller
  logic            cke;       // clock enable
  logic            cs_n;      // chip select
  logic            ras_n;     // command code bit
  logic            cas_n;     // command code bit
  logic            we_n;      // command code bit
  logic [2:0]      ba;        // bank / mode register select
  logic [AW-1:0]   addr;      // address
  logic            odt;       // termination control
  logic [NL-1:0]   dm;        // write data mask, one per lane
  logic [DQ_W-1:0] dq_c;      // data driven by controller
  logic            dq_c_oe;   // controller drives data
  logic [DQ_W-1:0] dq_d;      // data driven by device
  logic            dq_d_oe;   // device drives data
  logic            dqs_c;     // strobe driven by controller
  logic            dqs_c_oe;  // controller drives strobe
  logic            dqs_d;     // strobe driven by device
  logic            dqs_d_oe;  // device drives strobe
  logic [DQ_W-1:0] dq;        // resolved data wire
  logic            dqs;       // resolved strobe wire

  // wire resolution; an undriven bus reads as zero
  assign dq  = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);
  assign dqs = dqs_d_oe ? dqs_d : (dqs_c_oe ? dqs_c : 1'b0);

  modport ctrl (
    output ck, ck_n, link_rst, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm,
    output dq_c, dq_c_oe, dqs_c, dqs_c_oe,
    input  dq, dqs
  );

  modport mem (
    input  ck, ck_n, link_rst, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm,
    input  dq, dqs,
    output dq_d, dq_d_oe, dqs_d, dqs_d_oe
  );
endinterface

// ---- rtl/sdram_link_pkg.sv ----
// types shared by both ends of the memory link
package sdram_link_pkg;

  // power state of the memory device
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_PRE_PD = 2'b01,
    PWR_ACT_PD = 2'b10,
    PWR_SELF   = 2'b11
  } pwr_state_t;

  // request kinds accepted by the controller end
  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_ACT      = 4'h1,
    CMD_READ     = 4'h2,
    CMD_WRITE    = 4'h3,
    CMD_PRE      = 4'h4,
    CMD_MODE     = 4'h5,
    CMD_REFRESH  = 4'h6,
    CMD_SREF     = 4'h7,
    CMD_PD_ENTER = 4'h8,
    CMD_PD_EXIT  = 4'h9
  } cmd_t;

endpackage

// ---- rtl/sdram_link_regs.svh ----
// pin codes, field positions and timing counts shared by both link ends
`ifndef SDRAM_LINK_REGS_SVH
`define SDRAM_LINK_REGS_SVH

// data bus width of the organisation in use (16, 8 or 4)
`define LINK_DQ_W      16
// address pin count
`define LINK_AW        14
// device storage: address bits of the beat array, two beats per column
`define DEV_MEM_AW     5

// {ras_n, cas_n, we_n} levels while cs_n is low
`define CODE_MODE      3'h0
`define CODE_REFRESH   3'h1
`define CODE_PRE       3'h2
`define CODE_ACT       3'h3
`define CODE_WRITE     3'h4
`define CODE_READ      3'h5
`define CODE_NOP       3'h7

// address bit that turns a precharge into precharge-all
`define ADDR_AP_BIT    10
// mode register index and bit that allow on-die termination
`define EMR_INDEX      2'h1
`define EMR_TERM_BIT   2

// link clock is the system clock divided by four; phase of each action
`define PH_BEAT1       2'h1
`define PH_CMD         2'h3
// link clock periods from system reset until the first request is taken
`define INIT_PERIODS   3'h7
// link clock periods that the link reset is held; the rest of the init
// time lets the device's two-flop reset synchroniser settle first
`define LINK_RST_PERIODS 3'h4

`endif

// ---- verif/sdram_control_pin_sampling_test.sv ----
// top bench: controller and device ends joined by the link
`timescale 1ns/10ps
module sdram_control_pin_sampling_test;
  import sdram_link_pkg::*;
  logic        clk = 1'b0;       // system clock
  logic        srst = 1'b1;      // sync reset
  logic        req_valid = 1'b0; // request present
  cmd_t        req_cmd = CMD_NOP;
  logic [2:0]  req_ba = 3'h0;
  logic [13:0] req_addr = 14'h0;
  logic        req_odt = 1'b0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0]  req_wmask = 4'h0;
  logic        req_ready, rsp_valid, init_done, term_on;
  logic [31:0] rsp_rdata;
  pwr_state_t  pwr_state;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #4 clk = ~clk;
  sdram_link_if link ();
  sdram_ctrl_end i_sdram_ctrl_end (.clk, .srst, .link(link), .req_valid, .req_ready,
    .req_cmd, .req_ba, .req_addr, .req_odt, .req_wdata, .req_wmask, .rsp_valid,
    .rsp_rdata, .init_done);
  sdram_dev_end i_sdram_dev_end (.clk, .srst, .link(link), .pwr_state, .term_on);
  sdram_link_sva i_sdram_link_sva (.ck(link.ck), .link_rst(link.link_rst), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .dq_d_oe(link.dq_d_oe), .dqs_d(link.dqs_d), .dq_c_oe(link.dq_c_oe));
  ////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one request, held from a falling edge until taken; a hang ends in the timeout
  task req(input cmd_t c, input logic [2:0] b, input logic [13:0] a, input logic o,
           input logic [31:0] d, input logic [3:0] m);
    @(negedge clk);
    {req_cmd, req_ba, req_addr, req_odt, req_wdata, req_wmask} = {c, b, a, o, d, m};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task cmd(input cmd_t c, input logic [13:0] a);
    req(c, 3'h0, a, 1'b0, 32'h0, 4'h0);
  endtask
  task wait_pwr(input pwr_state_t e);
    for (int n = 0; n < 60 && pwr_state !== e; n++) @(negedge clk);
    chk("pwr_state", pwr_state, e);
  endtask
  task rd_chk(input logic [31:0] e);
    cmd(CMD_READ, 14'h0005);
    for (int n = 0; n < 30 && rsp_valid !== 1'b1; n++) @(negedge clk);
    chk("rsp_valid", rsp_valid, 32'h1);
    chk("rsp_rdata", rsp_rdata, e);
  endtask
  ////////////////////////////////////////////////////////////////
  // termination follows odt only while the mode bit allows it
  task t_term();
    req(CMD_MODE, 3'h1, 14'h0004, 1'b1, 32'h0, 4'h0);
    repeat (20) @(negedge clk);
    chk("term_on", term_on, 32'h1);
    req(CMD_MODE, 3'h1, 14'h0000, 1'b1, 32'h0, 4'h0);
    repeat (20) @(negedge clk);
    chk("term_on", term_on, 32'h0);
  endtask
  // full write, then a write masking one byte in each beat
  task t_data();
    cmd(CMD_ACT, 14'h0000);
    req(CMD_WRITE, 3'h0, 14'h0005, 1'b0, 32'hA1B2C3D4, 4'h0);
    rd_chk(32'hA1B2C3D4);
    req(CMD_WRITE, 3'h0, 14'h0005, 1'b0, 32'h55667788, 4'h9);
    rd_chk(32'hA16677D4);
  endtask
  // power-down kinds depend on open rows; self refresh exits on cke
  task t_power();
    cmd(CMD_PD_ENTER, 14'h0);
    wait_pwr(PWR_ACT_PD);
    cmd(CMD_PD_EXIT, 14'h0);
    wait_pwr(PWR_ACTIVE);
    cmd(CMD_PRE, 14'h0400);
    cmd(CMD_PD_ENTER, 14'h0);
    wait_pwr(PWR_PRE_PD);
    cmd(CMD_PD_EXIT, 14'h0);
    wait_pwr(PWR_ACTIVE);
    cmd(CMD_SREF, 14'h0);
    wait_pwr(PWR_SELF);
    cmd(CMD_PD_EXIT, 14'h0);
    wait_pwr(PWR_ACTIVE);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    while (init_done !== 1'b1) @(negedge clk);
    t_term();
    t_data();
    t_power();
    end_of_test();
  end
  // hang guard, far above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule // sdram_control_pin_sampling_test

// ---- verif/sdram_link_sva.sv ----
// concurrent checks on the memory link pins
`timescale 1ns/10ps
module sdram_link_sva (
  input wire logic ck,       // link clock
  input wire logic link_rst, // link reset
  input wire logic cke,      // clock enable
  input wire logic cs_n,     // chip select
  input wire logic ras_n,    // code bit
  input wire logic cas_n,    // code bit
  input wire logic we_n,     // code bit
  input wire logic dq_d_oe,  // device drives data
  input wire logic dqs_d,    // device strobe
  input wire logic dq_c_oe   // controller drives data
);
  // commands as the device decodes them
  wire logic rd = !cs_n && cke && ({ras_n, cas_n, we_n} == 3'h5);
  wire logic wr = !cs_n && cke && ({ras_n, cas_n, we_n} == 3'h4);
  ////////////////////////////////////////////////////////////////
  AST_IDLE_NOP: assert property (@(posedge ck) disable iff (link_rst)
    cs_n |-> {ras_n, cas_n, we_n} == 3'h7) else $error("idle code not nop");
  // back-to-back commands are legal, so a selected edge must carry a real code
  AST_CMD_ONE: assert property (@(posedge ck) disable iff (link_rst)
    !cs_n |-> {ras_n, cas_n, we_n} != 3'h7) else $error("selected edge has no command");
  AST_RD_DRIVE: assert property (@(negedge ck) disable iff (link_rst)
    rd |=> dq_d_oe) else $error("read data not driven");
  AST_RD_CAUSE: assert property (@(negedge ck) disable iff (link_rst)
    $rose(dq_d_oe) |-> $past(rd)) else $error("data driven without read");
  AST_RD_STROBE: assert property (@(negedge ck) disable iff (link_rst)
    dq_d_oe |-> dqs_d) else $error("read strobe not edge aligned");
  AST_RD_LEN: assert property (@(negedge ck) disable iff (link_rst)
    dq_d_oe |=> !dq_d_oe) else $error("read burst too long");
  AST_WR_DRIVE: assert property (@(negedge ck) disable iff (link_rst)
    wr |=> dq_c_oe && !dq_d_oe) else $error("write data not driven");
  AST_WR_LEN: assert property (@(negedge ck) disable iff (link_rst)
    dq_c_oe |=> !dq_c_oe) else $error("write burst too long");
  // main scenarios reached
  cover property (@(negedge ck) rd);
  cover property (@(negedge ck) wr);
  cover property (@(posedge ck) !cke);
  cover property (@(posedge ck) !cs_n);
endmodule // sdram_link_sva
